// >>> logic/rcal_pkg.sv
/*
 rcal_pkg: register map, field positions, reset values and timing counts
 of the calendar block. Assumes a 32-bit AXI4-Lite bus, 8-bit addresses.
*/
package rcal_pkg;
    // byte addresses
    localparam logic [7:0] RCAL_OFF_CFG = 8'h00;
    localparam logic [7:0] RCAL_OFF_PAD = 8'h04;
    localparam logic [7:0] RCAL_OFF_ALCFG = 8'h08;
    localparam logic [7:0] RCAL_OFF_VWIN = 8'h0c;
    localparam logic [7:0] RCAL_OFF_AWIN = 8'h10;
    localparam logic [7:0] RCAL_OFF_KEY = 8'h14;
    // config_trim_register fields
    localparam int RCAL_CFG_ON_BIT = 15;
    localparam int RCAL_CFG_UNLOCK_BIT = 13;
    localparam int RCAL_CFG_ROLL_BIT = 12;
    localparam int RCAL_CFG_HALF_BIT = 11;
    localparam int RCAL_CFG_OE_BIT = 10;
    localparam int RCAL_PTR_LSB = 8;
    localparam logic [15:0] RCAL_CFG_RST = 16'h0000;
    // pad_output_config field
    localparam int RCAL_PAD_SEL_BIT = 1;
    // alarm_setup_register fields
    localparam int RCAL_AL_ON_BIT = 15;
    localparam int RCAL_AL_REPEAT_WRAP_ON_BIT = 14;
    localparam int RCAL_AL_MASK_LSB = 10;
    localparam logic [15:0] RCAL_ALCFG_RST = 16'h0000;
    // unlock key sequence
    localparam logic [7:0] RCAL_KEY_FIRST = 8'h55;
    localparam logic [7:0] RCAL_KEY_SECOND = 8'haa;
    // calendar reset values: 2000-01-01 00:00:00
    localparam logic [7:0] RCAL_YEAR_RST = 8'h00;
    localparam logic [7:0] RCAL_MON_RST = 8'h01;
    localparam logic [7:0] RCAL_DAY_RST = 8'h01;
    // time base, in 32.768 kHz pulses
    localparam logic [16:0] RCAL_SEC_PULSES = 17'h0_8000;
    localparam logic [15:0] RCAL_HALF_PULSES = 16'h4000;
    localparam logic [15:0] RCAL_ROLL_LEAD = 16'h0020;
    // axi responses
    localparam logic [1:0] RCAL_RESP_OKAY = 2'b00;
    localparam logic [1:0] RCAL_RESP_SLVERR = 2'b10;

    typedef enum logic [3:0] {
        RCAL_AM_HALF = 4'b0000,
        RCAL_AM_SEC = 4'b0001,
        RCAL_AM_10SEC = 4'b0010,
        RCAL_AM_MIN = 4'b0011,
        RCAL_AM_10MIN = 4'b0100,
        RCAL_AM_HOUR = 4'b0101,
        RCAL_AM_DAY = 4'b0110,
        RCAL_AM_WEEK = 4'b0111,
        RCAL_AM_MONTH = 4'b1000,
        RCAL_AM_YEAR = 4'b1001
    } rcal_mask_t;

    typedef enum logic [1:0] {
        RCAL_KEY_IDLE = 2'b00,
        RCAL_KEY_HALF = 2'b01,
        RCAL_KEY_ARMED = 2'b10
    } rcal_key_t;
endpackage

// >>> logic/rcal_timebase.sv
/*
 rcal_timebase: synchronises the 32.768 kHz pin and divides it into
 second and half-second pulses, with once-a-minute drift trim.
 Assumes aclk is much faster than the oscillator pin.
*/
`timescale 1ns/1ps
module rcal_timebase (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // oscillator pin
    input wire logic osc_32k,
    // control
    input wire logic run,
    input wire logic restart,
    input wire logic trim_now,
    input wire logic [7:0] trim,
    // status
    output logic sec_tick,
    output logic half_tick,
    output logic second_half,
    output logic near_roll
);
    import rcal_pkg::*;

    logic [2:0] osc_sync_q;
    logic [15:0] count_q;
    logic [16:0] period;
    logic [15:0] last;
    logic osc_edge;

    // stage 0 feeds stage 1 only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_sync_q <= 3'h0;
        end else begin
            osc_sync_q <= {osc_sync_q[1:0], osc_32k};
        end
    end

    assign osc_edge = osc_sync_q[1] && !osc_sync_q[2];

    // positive trim shortens the trimmed second, negative lengthens it
    always_comb begin
        period = RCAL_SEC_PULSES;
        if (trim_now) begin
            period = RCAL_SEC_PULSES - {{7{trim[7]}}, trim, 2'b00};
        end
        last = 16'(period - 17'h0_0001); // longest trimmed second still fits 16 bits
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= 16'h0000;
            sec_tick <= 1'b0;
            half_tick <= 1'b0;
        end else begin
            sec_tick <= 1'b0;
            half_tick <= 1'b0;
            if (restart) begin
                count_q <= 16'h0000;
            end else if (run && osc_edge) begin
                if (count_q >= last) begin
                    count_q <= 16'h0000;
                    sec_tick <= 1'b1;
                end else begin
                    count_q <= count_q + 16'h0001;
                    half_tick <= (count_q == RCAL_HALF_PULSES - 16'h0001);
                end
            end
        end
    end

    assign second_half = (count_q >= RCAL_HALF_PULSES);
    // a guard band before the carry ripples through the fields
    assign near_roll = run && (count_q >= last - RCAL_ROLL_LEAD);
endmodule // rcal_timebase

// >>> logic/rcal_top.sv
/*
 rcal_top: BCD clock/calendar with alarm behind an AXI4-Lite slave.
 Assumes one 20 MHz aclk, an asynchronous 32.768 kHz pin and a
 power-on reset input separate from the bus reset.
*/
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
// Operation
// - value window high byte access decrements its pointer, stopping at 00.
// - alarm pointer picks alarm min/sec, weekday/hour, month/day; 11 none.
// - alarm window high byte write decrements alarm pointer, stopping at 00.
// - reading either byte of either window decrements its pointer.
// - unlock bit sets only right after 0x55 then 0xAA key writes.
// - rollover pending flag warns that window reads may tear.
// - half-second flag shows second half; seconds byte write clears it.
// - pin source select: 1 seconds clock, 0 alarm pulse.
// - signed trim adjusts time base once a minute, 4 pulses per count.
// - config and trim register resets on power-on reset only.
// - alarm enable self-clears after event when count 0 and no wrap.
// - repeat count decrements on alarm events unless count 0 and no wrap.
// - interval select sets alarm period, half second up to year.
// - year is two BCD digits in low byte; high byte reads zero.
// - month BCD read-only in time window; day BCD tens and ones.
// - weekday 0 to 6 in bits 10-8; hour BCD in 24-hour form.
// - unimplemented bits read zero and ignore writes.
// - minutes high byte, seconds low byte, BCD tens 0-5, ones 0-9.
// - calendar spans 2000 to 2099 with leap years.
// - time is kept from the external 32.768 kHz pin.
`timescale 1ns/1ps
module rcal_top (
    // clock and resets
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_n,
    // oscillator pin
    input wire logic osc_32k,
    // axi write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    // axi write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    // axi read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // clock pin and event
    output logic clk_pin_o,
    output logic clk_pin_oe,
    output logic alarm_event
);
    import rcal_pkg::*;

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == RCAL_OFF_CFG) || (a == RCAL_OFF_PAD) || (a == RCAL_OFF_ALCFG)
            || (a == RCAL_OFF_VWIN) || (a == RCAL_OFF_AWIN) || (a == RCAL_OFF_KEY);
    endfunction

    // next bcd value, wrapping from last to first
    function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] lst,
                                            input logic [7:0] first);
        if (v == lst) begin
            bcd_step = first;
        end else if (v[3:0] == 4'h9) begin
            bcd_step = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_step = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // last day of month; years 2000..2099 are leap when divisible by 4
    function automatic logic [7:0] last_day(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        case (mon)
            8'h02: last_day = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
            default: last_day = 8'h31;
        endcase
    endfunction

    // bus state
    logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
    logic [7:0] aw_addr_q;
    logic [15:0] w_data_q;
    logic [1:0] w_strb_q, bresp_q, rresp_q;
    logic [31:0] rdata_q, rd_word;
    logic wr_go, rd_go, wr_hi, wr_lo;
    logic wr_cfg, wr_pad, wr_alcfg, wr_vwin, wr_awin, wr_key, rd_vwin, rd_awin;
    // config, pad, alarm setup
    logic on_q, unlock_q, oe_q, sel_q, al_on_q, repeat_wrap_on_q;
    logic [1:0] vptr_q, aptr_q;
    logic [7:0] cal_q, rpt_q;
    logic [3:0] mask_q;
    rcal_key_t key_q;
    // calendar and alarm fields
    logic [7:0] sec_q, min_q, hour_q, day_q, mon_q, year_q;
    logic [2:0] weekday_value_q, a_weekday_value_q;
    logic [7:0] a_sec_q, a_min_q, a_hour_q, a_day_q, a_mon_q;
    // time base and alarm
    logic sec_tick, half_tick, second_half, near_roll, tick_q, due, al_event, clr_half;

    assign awready = !aw_got_q && !bvalid_q;
    assign wready = !w_got_q && !bvalid_q;
    assign arready = !rvalid_q;
    assign wr_go = aw_got_q && w_got_q && !bvalid_q;
    assign rd_go = arvalid && arready;
    assign wr_hi = w_strb_q[1];
    assign wr_lo = w_strb_q[0];
    assign wr_cfg = wr_go && (aw_addr_q == RCAL_OFF_CFG);
    assign wr_pad = wr_go && (aw_addr_q == RCAL_OFF_PAD);
    assign wr_alcfg = wr_go && (aw_addr_q == RCAL_OFF_ALCFG);
    assign wr_vwin = wr_go && (aw_addr_q == RCAL_OFF_VWIN);
    assign wr_awin = wr_go && (aw_addr_q == RCAL_OFF_AWIN);
    assign wr_key = wr_go && (aw_addr_q == RCAL_OFF_KEY);
    assign rd_vwin = rd_go && (araddr == RCAL_OFF_VWIN);
    assign rd_awin = rd_go && (araddr == RCAL_OFF_AWIN);
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // address and data are taken in either order, then answered together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_got_q <= 1'b0;
            w_data_q <= 16'h0000;
            w_strb_q <= 2'b00;
            bvalid_q <= 1'b0;
            bresp_q <= RCAL_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_got_q <= 1'b1;
                aw_addr_q <= awaddr;
            end else if (wr_go) begin
                aw_got_q <= 1'b0;
            end
            if (wvalid && wready) begin
                w_got_q <= 1'b1;
                w_data_q <= wdata[15:0];
                w_strb_q <= wstrb[1:0];
            end else if (wr_go) begin
                w_got_q <= 1'b0;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= addr_known(aw_addr_q) ? RCAL_RESP_OKAY : RCAL_RESP_SLVERR;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (araddr)
            RCAL_OFF_CFG: rd_word[15:0] = {on_q, 1'b0, unlock_q, near_roll, second_half, oe_q,
                                           vptr_q, cal_q};
            RCAL_OFF_PAD: rd_word[RCAL_PAD_SEL_BIT] = sel_q;
            RCAL_OFF_ALCFG: rd_word[15:0] = {al_on_q, repeat_wrap_on_q, mask_q, aptr_q, rpt_q};
            RCAL_OFF_VWIN: begin
                case (vptr_q)
                    2'b00: rd_word[15:0] = {min_q, sec_q};
                    2'b01: rd_word[15:0] = {5'h00, weekday_value_q, hour_q};
                    2'b10: rd_word[15:0] = {mon_q, day_q};
                    default: rd_word[15:0] = {8'h00, year_q};
                endcase
            end
            RCAL_OFF_AWIN: begin
                case (aptr_q)
                    2'b00: rd_word[15:0] = {a_min_q, a_sec_q};
                    2'b01: rd_word[15:0] = {5'h00, a_weekday_value_q, a_hour_q};
                    2'b10: rd_word[15:0] = {a_mon_q, a_day_q};
                    default: rd_word[15:0] = 16'h0000;
                endcase
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RCAL_RESP_OKAY;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= addr_known(araddr) ? RCAL_RESP_OKAY : RCAL_RESP_SLVERR;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // the window is the very next bus write after the key pair
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key_q <= RCAL_KEY_IDLE;
        end else if (wr_go) begin
            if (wr_key && wr_lo && w_data_q[7:0] == RCAL_KEY_FIRST) begin
                key_q <= RCAL_KEY_HALF;
            end else if (wr_key && wr_lo && w_data_q[7:0] == RCAL_KEY_SECOND
                         && key_q == RCAL_KEY_HALF) begin
                key_q <= RCAL_KEY_ARMED;
            end else begin
                key_q <= RCAL_KEY_IDLE;
            end
        end
    end

    // survives bus reset, though the calendar fields and time base reset with it
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            on_q <= RCAL_CFG_RST[RCAL_CFG_ON_BIT];
            unlock_q <= RCAL_CFG_RST[RCAL_CFG_UNLOCK_BIT];
            oe_q <= RCAL_CFG_RST[RCAL_CFG_OE_BIT];
            vptr_q <= RCAL_CFG_RST[RCAL_PTR_LSB +: 2];
            cal_q <= RCAL_CFG_RST[7:0];
        end else begin
            if (wr_cfg && wr_lo) begin
                cal_q <= w_data_q[7:0];
            end
            if (wr_cfg && wr_hi) begin
                oe_q <= w_data_q[RCAL_CFG_OE_BIT];
                if (unlock_q) begin
                    on_q <= w_data_q[RCAL_CFG_ON_BIT];
                end
                unlock_q <= w_data_q[RCAL_CFG_UNLOCK_BIT]
                    && (unlock_q || key_q == RCAL_KEY_ARMED);
                vptr_q <= w_data_q[RCAL_PTR_LSB +: 2];
            end else if ((rd_vwin || (wr_vwin && wr_hi)) && vptr_q != 2'b00) begin
                vptr_q <= vptr_q - 2'b01;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_q <= 1'b0;
        end else if (wr_pad && wr_lo) begin
            sel_q <= w_data_q[RCAL_PAD_SEL_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            al_on_q <= RCAL_ALCFG_RST[RCAL_AL_ON_BIT];
            repeat_wrap_on_q <= RCAL_ALCFG_RST[RCAL_AL_REPEAT_WRAP_ON_BIT];
            mask_q <= RCAL_ALCFG_RST[RCAL_AL_MASK_LSB +: 4];
            aptr_q <= RCAL_ALCFG_RST[RCAL_PTR_LSB +: 2];
            rpt_q <= RCAL_ALCFG_RST[7:0];
        end else begin
            if (al_event) begin
                if (rpt_q == 8'h00 && !repeat_wrap_on_q) begin
                    al_on_q <= 1'b0;
                end else begin
                    rpt_q <= rpt_q - 8'h01;
                end
            end
            if (wr_alcfg && wr_lo) begin
                rpt_q <= w_data_q[7:0];
            end
            if (wr_alcfg && wr_hi) begin
                al_on_q <= w_data_q[RCAL_AL_ON_BIT];
                repeat_wrap_on_q <= w_data_q[RCAL_AL_REPEAT_WRAP_ON_BIT];
                mask_q <= w_data_q[RCAL_AL_MASK_LSB +: 4];
                aptr_q <= w_data_q[RCAL_PTR_LSB +: 2];
            end else if ((rd_awin || (wr_awin && wr_hi)) && aptr_q != 2'b00) begin
                aptr_q <= aptr_q - 2'b01;
            end
        end
    end

    // alarm fields; pointer 11 holds nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_sec_q <= 8'h00;
            a_min_q <= 8'h00;
            a_hour_q <= 8'h00;
            a_weekday_value_q <= 3'h0;
            a_day_q <= RCAL_DAY_RST;
            a_mon_q <= RCAL_MON_RST;
        end else if (wr_awin) begin
            case (aptr_q)
                2'b00: begin
                    if (wr_hi) a_min_q <= {1'b0, w_data_q[14:8]};
                    if (wr_lo) a_sec_q <= {1'b0, w_data_q[6:0]};
                end
                2'b01: begin
                    if (wr_hi) a_weekday_value_q <= w_data_q[10:8];
                    if (wr_lo) a_hour_q <= {2'b00, w_data_q[5:0]};
                end
                2'b10: begin
                    if (wr_hi) a_mon_q <= {3'b000, w_data_q[12:8]};
                    if (wr_lo) a_day_q <= {2'b00, w_data_q[5:0]};
                end
                default: a_sec_q <= a_sec_q;
            endcase
        end
    end

    // a locked write attempt to the seconds byte still restarts the second
    assign clr_half = wr_vwin && wr_lo && vptr_q == 2'b00;

    rcal_timebase u_timebase (
        .aclk(aclk),
        .aresetn(aresetn),
        .osc_32k(osc_32k),
        .run(on_q),
        .restart(clr_half),
        .trim_now(sec_q == 8'h59),
        .trim(cal_q),
        .sec_tick(sec_tick),
        .half_tick(half_tick),
        .second_half(second_half),
        .near_roll(near_roll)
    );

    // ripple carry; an unlocked software write wins over the tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sec_q <= 8'h00;
            min_q <= 8'h00;
            hour_q <= 8'h00;
            weekday_value_q <= 3'h0;
            day_q <= RCAL_DAY_RST;
            mon_q <= RCAL_MON_RST;
            year_q <= RCAL_YEAR_RST;
        end else begin
            if (sec_tick) begin
                sec_q <= bcd_step(sec_q, 8'h59, 8'h00);
                if (sec_q == 8'h59) begin
                    min_q <= bcd_step(min_q, 8'h59, 8'h00);
                    if (min_q == 8'h59) begin
                        hour_q <= bcd_step(hour_q, 8'h23, 8'h00);
                        if (hour_q == 8'h23) begin
                            weekday_value_q <= (weekday_value_q == 3'h6) ? 3'h0 : weekday_value_q + 3'h1;
                            day_q <= bcd_step(day_q, last_day(mon_q, year_q), 8'h01);
                            if (day_q == last_day(mon_q, year_q)) begin
                                mon_q <= bcd_step(mon_q, 8'h12, 8'h01);
                                if (mon_q == 8'h12) begin
                                    year_q <= bcd_step(year_q, 8'h99, 8'h00);
                                end
                            end
                        end
                    end
                end
            end
            if (wr_vwin && unlock_q) begin
                case (vptr_q)
                    2'b00: begin
                        if (wr_hi) min_q <= {1'b0, w_data_q[14:8]};
                        if (wr_lo) sec_q <= {1'b0, w_data_q[6:0]};
                    end
                    2'b01: begin
                        if (wr_hi) weekday_value_q <= w_data_q[10:8];
                        if (wr_lo) hour_q <= {2'b00, w_data_q[5:0]};
                    end
                    2'b10: begin
                        if (wr_lo) day_q <= {2'b00, w_data_q[5:0]};
                    end
                    default: begin
                        if (wr_lo) year_q <= w_data_q[7:0];
                    end
                endcase
            end
        end
    end

    // compare one cycle after the tick, once the fields have settled
    always_comb begin
        case (mask_q)
            RCAL_AM_HALF: due = tick_q || half_tick;
            RCAL_AM_SEC: due = tick_q;
            RCAL_AM_10SEC: due = tick_q && sec_q[3:0] == a_sec_q[3:0];
            RCAL_AM_MIN: due = tick_q && sec_q == a_sec_q;
            RCAL_AM_10MIN: due = tick_q && sec_q == a_sec_q && min_q[3:0] == a_min_q[3:0];
            RCAL_AM_HOUR: due = tick_q && sec_q == a_sec_q && min_q == a_min_q;
            RCAL_AM_DAY: due = tick_q && {hour_q, min_q, sec_q} == {a_hour_q, a_min_q, a_sec_q};
            RCAL_AM_WEEK: due = tick_q && {weekday_value_q, hour_q, min_q, sec_q}
                == {a_weekday_value_q, a_hour_q, a_min_q, a_sec_q};
            RCAL_AM_MONTH: due = tick_q && {day_q, hour_q, min_q, sec_q}
                == {a_day_q, a_hour_q, a_min_q, a_sec_q};
            RCAL_AM_YEAR: due = tick_q && {mon_q, day_q, hour_q, min_q, sec_q}
                == {a_mon_q, a_day_q, a_hour_q, a_min_q, a_sec_q};
            default: due = 1'b0;
        endcase
    end

    assign al_event = al_on_q && due;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_q <= 1'b0;
            alarm_event <= 1'b0;
            clk_pin_o <= 1'b0;
            clk_pin_oe <= 1'b0;
        end else begin
            tick_q <= sec_tick;
            alarm_event <= al_event;
            clk_pin_o <= sel_q ? !second_half : al_event;
            clk_pin_oe <= oe_q;
        end
    end
endmodule // rcal_top

// >>> tb/rcal_top_props.sv
/* rcal_top_props: port assertions for rcal_top.
 Assumes a bind onto rcal_top; one clock domain. */
`timescale 1ns/1ps
module rcal_top_props (
    input wire logic aclk, aresetn, por_n, awready, wready, bvalid, bready,
    input wire logic arvalid, arready, rvalid, rready, clk_pin_oe, alarm_event,
    input wire logic [1:0] bresp, rresp,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_event_pulse: assert property (alarm_event |=> !alarm_event)
        else $error("alarm event too long");
    a_upper_zero: assert property (rvalid |-> rdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_slverr_zero: assert property (rvalid && rresp[1] |-> rdata == 32'h0000_0000)
        else $error("refused read not zero");
    a_por_oe_off: assert property (!por_n |=> ##1 !clk_pin_oe)
        else $error("pin enable after power-on reset");
    a_rd_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read not answered");
    a_wr_busy: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while busy");
    a_b_clear: assert property (bvalid && bready |=> !bvalid)
        else $error("write response repeated");
    a_r_clear: assert property (rvalid && rready |=> !rvalid)
        else $error("read response repeated");
endmodule // rcal_top_props
bind rcal_top rcal_top_props rcal_top_props_u (.aclk, .aresetn, .por_n, .awready, .wready,
    .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .clk_pin_oe, .alarm_event,
    .bresp, .rresp, .rdata);

// >>> tb/tb_rcal_top.sv
/* tb_rcal_top: register bench for rcal_top.
 Assumes time stays frozen until the last tests drive the oscillator pin. */
`timescale 1ns/1ps
module tb_rcal_top;
    import rcal_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0, osc_32k = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, lfsr = 32'heb57_7ef8, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, clk_pin_o, clk_pin_oe, alarm_event;
    logic [1:0] bresp, rresp, last_b;
    logic [15:0] vwin [4];
    logic [15:0] al;
    int mismatches = 0, n_checks = 0;
    int n_events = 0, n_pin = 0, pin0 = 0;
    always #25 aclk = ~aclk;
    // outputs are settled by the falling edge
    always @(negedge aclk) begin
        if (alarm_event) n_events++;
        if (clk_pin_o) n_pin++;
    end
    rcal_top dut_u (.aclk, .aresetn, .por_n, .osc_32k, .awvalid, .awready, .awaddr, .wvalid,
        .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .rvalid, .rready, .rdata, .rresp, .clk_pin_o, .clk_pin_oe, .alarm_event);
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= s;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        last_b = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er = 2'b00);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk({rresp, rdata}, {er, 16'h0000, e});
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge aclk);
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        rd(RCAL_OFF_CFG, 16'h0000);
        rd(8'h18, 16'h0000, RCAL_RESP_SLVERR);
        wr(8'h18, 16'hffff, 4'h3);
        chk(last_b, RCAL_RESP_SLVERR);
        wr(RCAL_OFF_CFG, 16'ha000, 4'h3);
        rd(RCAL_OFF_CFG, 16'h0000);
        wr(RCAL_OFF_KEY, 16'h0055, 4'h1);
        wr(RCAL_OFF_KEY, 16'h00aa, 4'h1);
        wr(RCAL_OFF_CFG, 16'h2000, 4'h3);
        wr(RCAL_OFF_CFG, 16'ha700, 4'h3);
        rd(RCAL_OFF_CFG, 16'ha700);
        chk(clk_pin_oe, 1'b1);
        $display("test unlock done");
        lfsr = nxt(lfsr);
        vwin = '{16'h0000, 16'h0000, 16'h0101, {8'h00, 4'(lfsr[7:4] % 10), 4'(lfsr[3:0] % 10)}};
        wr(RCAL_OFF_VWIN, vwin[3], 4'h1);
        for (int i = 3; i >= -1; i--) begin
            rd(RCAL_OFF_VWIN, vwin[i < 0 ? 0 : i]);
        end
        wr(RCAL_OFF_CFG, 16'h8700, 4'h3);
        wr(RCAL_OFF_VWIN, 16'h0099, 4'h1);
        rd(RCAL_OFF_VWIN, vwin[3]);
        $display("test window done");
        lfsr = nxt(lfsr);
        al = {8'h26, lfsr[7:0]};
        wr(RCAL_OFF_ALCFG, al, 4'h3);
        wr(RCAL_OFF_AWIN, 16'h1231, 4'h3);
        rd(RCAL_OFF_ALCFG, al - 16'h0100);
        wr(RCAL_OFF_AWIN, 16'h0023, 4'h1);
        rd(RCAL_OFF_AWIN, 16'h0023);
        rd(RCAL_OFF_AWIN, 16'h0000);
        wr(RCAL_OFF_ALCFG, al | 16'h0100, 4'h3);
        rd(RCAL_OFF_AWIN, 16'h0000);
        rd(RCAL_OFF_AWIN, 16'h1231);
        wr(RCAL_OFF_PAD, 16'hffff, 4'h3);
        rd(RCAL_OFF_PAD, 16'h0002);
        $display("test alarm done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(RCAL_OFF_CFG, 16'h8600);
        rd(RCAL_OFF_ALCFG, 16'h0000);
        $display("test reset done");
        wr(RCAL_OFF_ALCFG, 16'h8000, 4'h3);
        pin0 = n_pin;
        // three aclk per oscillator edge; 16400 edges pass the half second
        repeat (16400) begin
            osc_32k <= 1'b1;
            repeat (2) @(posedge aclk);
            osc_32k <= 1'b0;
            @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
        chk(n_events, 1);
        chk(n_pin - pin0, 1);
        rd(RCAL_OFF_ALCFG, 16'h0000);
        rd(RCAL_OFF_CFG, 16'h8e00);
        wr(RCAL_OFF_CFG, 16'h8400, 4'h3);
        wr(RCAL_OFF_VWIN, 16'h0000, 4'h1);
        rd(RCAL_OFF_CFG, 16'h8400);
        $display("test half second done");
        por_n <= 1'b0;
        repeat (2) @(posedge aclk);
        por_n <= 1'b1;
        rd(RCAL_OFF_CFG, 16'h0000);
        chk(clk_pin_oe, 1'b0);
        $display("test power-on done");
        print_verdict();
    end
endmodule // tb_rcal_top
